// ===== logic/timer_pkg.sv
// constants, register map and shared decode for the period match timer
package timer_pkg;

	// register offsets on the plain register port
	localparam logic [2:0] ADDR_COUNT = 3'h0;
	localparam logic [2:0] ADDR_PERIOD = 3'h1;
	localparam logic [2:0] ADDR_CONTROL = 3'h2;
	localparam logic [2:0] ADDR_STATUS = 3'h3;
	localparam logic [2:0] ADDR_MASK = 3'h4;

	// timer_control field positions
	localparam int PRE_SEL_LSB = 0;
	localparam int RUN_BIT = 2;
	localparam int POST_SEL_LSB = 3;

	// status and mask layout
	localparam int MATCH_FLAG_BIT = 0;

	// reset values
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] PERIOD_RESET = 8'hff;
	localparam logic [6:0] CONTROL_RESET = 7'h00;

	// instruction clock is the oscillator divided by four
	localparam logic [1:0] INSTR_LAST = 2'h3;

	// prescaler terminal counts for 1:1, 1:4 and 1:16
	localparam logic [3:0] PRE_LAST_1 = 4'h0;
	localparam logic [3:0] PRE_LAST_4 = 4'h3;
	localparam logic [3:0] PRE_LAST_16 = 4'hf;

	function automatic logic [3:0] pre_limit(input logic [1:0] sel);
		case (sel)
			2'b00: pre_limit = PRE_LAST_1;
			2'b01: pre_limit = PRE_LAST_4;
			default: pre_limit = PRE_LAST_16;
		endcase
	endfunction

endpackage

// ===== logic/tick_prescaler.sv
// instruction clock divider and selectable prescaler
`timescale 1ns/100ps
`default_nettype none

module tick_prescaler
	import timer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic run,
	input wire logic clr,
	input wire logic [1:0] pre_divide_sel,
	output logic inc
);

	logic [1:0] phase_q;
	logic [1:0] phase_d;
	logic [3:0] pre_cnt_q;
	logic [3:0] pre_cnt_d;
	logic instr_tick;

	// phase runs free so a clear never shortens an instruction cycle
	assign instr_tick = (phase_q == INSTR_LAST);
	assign inc = run && instr_tick && !clr
		&& (pre_cnt_q == pre_limit(pre_divide_sel));

	always_comb begin
		phase_d = phase_q + 2'h1;
		pre_cnt_d = pre_cnt_q;
		if (clr) begin
			pre_cnt_d = 4'h0;
		end else if (run && instr_tick) begin
			if (pre_cnt_q == pre_limit(pre_divide_sel)) begin
				pre_cnt_d = 4'h0;
			end else begin
				pre_cnt_d = pre_cnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			phase_q <= 2'h0;
			pre_cnt_q <= 4'h0;
		end else begin
			phase_q <= phase_d;
			pre_cnt_q <= pre_cnt_d;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	pre_terminal_a: assert property (
		inc |-> pre_cnt_q == pre_limit(pre_divide_sel))
		else $error("prescaler pulse off its terminal count");
	instr_spacing_a: assert property (
		inc |=> !inc [*3])
		else $error("increments closer than one instruction cycle");
	pre_clear_a: assert property (
		clr |=> pre_cnt_q == 4'h0)
		else $error("prescaler not cleared");

endmodule // tick_prescaler

`default_nettype wire

// ===== logic/period_match_timer.sv
// 8-bit period match timer with prescaler, postscaler and interrupt
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module period_match_timer
	import timer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	output logic irq,
	output logic post_pulse
);

	// architectural state
	logic [7:0] timer2_count_q;
	logic [7:0] timer2_count_d;
	logic [7:0] period_value_q;
	logic [7:0] period_value_d;
	logic [6:0] timer_control_q;
	logic [6:0] timer_control_d;
	logic match_flag_q;
	logic match_flag_d;
	logic match_irq_enable_q;
	logic match_irq_enable_d;

	// divider and output state
	logic [3:0] post_cnt_q;
	logic [3:0] post_cnt_d;
	logic post_pulse_q;
	logic post_pulse_d;
	logic irq_q;
	logic irq_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// decoded strobes and fields
	logic wr_count;
	logic wr_period;
	logic wr_control;
	logic wr_status;
	logic wr_mask;
	logic timer_run;
	logic [1:0] pre_divide_sel;
	logic [3:0] post_divide_sel;
	logic div_clr;
	logic inc;
	logic at_match;
	logic wrap;
	logic post_fire;

	assign wr_count = wr_en && (addr == ADDR_COUNT);
	assign wr_period = wr_en && (addr == ADDR_PERIOD);
	assign wr_control = wr_en && (addr == ADDR_CONTROL);
	assign wr_status = wr_en && (addr == ADDR_STATUS);
	assign wr_mask = wr_en && (addr == ADDR_MASK);

	assign timer_run = timer_control_q[RUN_BIT];
	assign pre_divide_sel = timer_control_q[PRE_SEL_LSB +: 2];
	assign post_divide_sel = timer_control_q[POST_SEL_LSB +: 4];

	// prescaler and postscaler restart whenever software moves the count or the setup
	assign div_clr = wr_count || wr_control;

	tick_prescaler u_prescaler (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.run(timer_run),
		.clr(div_clr),
		.pre_divide_sel(pre_divide_sel),
		.inc(inc)
	);

	// comparator is purely combinational, so it sees every count value
	assign at_match = (timer2_count_q == period_value_q);
	assign wrap = inc && at_match && !wr_count;
	assign post_fire = wrap && (post_cnt_q == post_divide_sel);

	// count and period
	always_comb begin
		timer2_count_d = timer2_count_q;
		period_value_d = period_value_q;
		if (wr_count) begin
			// software write wins over a pending increment
			timer2_count_d = wdata;
		end else if (inc) begin
			if (at_match) begin
				timer2_count_d = 8'h00;
			end else begin
				timer2_count_d = timer2_count_q + 8'h01;
			end
		end
		if (wr_period) begin
			period_value_d = wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			timer2_count_q <= COUNT_RESET;
			period_value_q <= PERIOD_RESET;
		end else begin
			timer2_count_q <= timer2_count_d;
			period_value_q <= period_value_d;
		end
	end

	// control and postscaler
	always_comb begin
		timer_control_d = timer_control_q;
		post_cnt_d = post_cnt_q;
		post_pulse_d = 1'b0;
		if (wr_control) begin
			// count itself is left alone here
			timer_control_d = wdata[6:0];
		end
		if (div_clr) begin
			post_cnt_d = 4'h0;
		end else if (wrap) begin
			if (post_fire) begin
				post_cnt_d = 4'h0;
				post_pulse_d = 1'b1;
			end else begin
				post_cnt_d = post_cnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			timer_control_q <= CONTROL_RESET;
			post_cnt_q <= 4'h0;
			post_pulse_q <= 1'b0;
		end else begin
			timer_control_q <= timer_control_d;
			post_cnt_q <= post_cnt_d;
			post_pulse_q <= post_pulse_d;
		end
	end

	// flag, enable and interrupt line
	always_comb begin
		match_flag_d = match_flag_q;
		match_irq_enable_d = match_irq_enable_q;
		if (wr_status && wdata[MATCH_FLAG_BIT]) begin
			match_flag_d = 1'b0;
		end
		// set after clear so a same-cycle event is never lost
		if (post_fire) begin
			match_flag_d = 1'b1;
		end
		if (wr_mask) begin
			match_irq_enable_d = wdata[MATCH_FLAG_BIT];
		end
		// from next values so irq tracks the flag in the same cycle
		irq_d = match_flag_d && match_irq_enable_d;
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			match_flag_q <= 1'b0;
			match_irq_enable_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			match_flag_q <= match_flag_d;
			match_irq_enable_q <= match_irq_enable_d;
			irq_q <= irq_d;
		end
	end

	// read path: data valid only in the cycle after the strobe
	always_comb begin
		rdata_d = 8'h00;
		if (rd_en) begin
			case (addr)
				ADDR_COUNT: rdata_d = timer2_count_q;
				ADDR_PERIOD: rdata_d = period_value_q;
				ADDR_CONTROL: rdata_d = {1'b0, timer_control_q};
				ADDR_STATUS: rdata_d = {7'h00, match_flag_q};
				ADDR_MASK: rdata_d = {7'h00, match_irq_enable_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;
	assign irq = irq_q;
	assign post_pulse = post_pulse_q;

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence plain_step_s;
		inc && !at_match && !wr_count;
	endsequence

	sequence match_step_s;
		inc && at_match && !wr_count;
	endsequence

	sequence last_match_s;
		match_step_s ##0 (post_cnt_q == post_divide_sel) ##0 !wr_control;
	endsequence

	// stopped, and no count write in the cycle after either
	sequence idle_pair_s;
		(!timer_run && !wr_count && !wr_control) ##1 !wr_count;
	endsequence

	reset_values_a: assert property (
		$rose(nrst) |-> timer2_count_q == COUNT_RESET
		&& period_value_q == PERIOD_RESET)
		else $error("count or period wrong after reset");

	count_step_a: assert property (
		plain_step_s |=>
		timer2_count_q == $past(timer2_count_q) + 8'h01)
		else $error("count did not step by one");

	count_wrap_a: assert property (
		match_step_s |=> timer2_count_q == 8'h00)
		else $error("count did not wrap to zero on match");

	count_hold_a: assert property (
		!inc && !wr_count |=> $stable(timer2_count_q))
		else $error("count moved without an increment");

	stopped_hold_a: assert property (
		idle_pair_s |-> $stable(timer2_count_q)
		##1 $stable(timer2_count_q))
		else $error("count moved while stopped");

	control_keep_a: assert property (
		wr_control |=> $stable(timer2_count_q))
		else $error("control write disturbed the count");

	post_clear_a: assert property (
		div_clr |=> post_cnt_q == 4'h0)
		else $error("postscaler not cleared");

	post_step_a: assert property (
		wrap && !post_fire |=>
		post_cnt_q == $past(post_cnt_q) + 4'h1)
		else $error("postscaler did not advance on a match");

	post_bound_a: assert property (
		post_cnt_q <= post_divide_sel || $past(wr_control))
		else $error("postscaler passed its terminal count");

	flag_set_a: assert property (
		last_match_s |=> match_flag_q && post_pulse_q
		&& post_cnt_q == 4'h0)
		else $error("postscaler output did not set the flag");

	flag_cause_a: assert property (
		!match_flag_q && !post_fire |=> !match_flag_q)
		else $error("flag set without a postscaler output");

	flag_sticky_a: assert property (
		match_flag_q && !(wr_status && wdata[MATCH_FLAG_BIT])
		|=> match_flag_q)
		else $error("flag dropped without a clear");

	flag_clear_a: assert property (
		wr_status && wdata[MATCH_FLAG_BIT] && !post_fire
		|=> !match_flag_q)
		else $error("flag not cleared by a write of one");

	irq_level_a: assert property (
		irq == (match_flag_q && match_irq_enable_q))
		else $error("irq disagrees with flag and enable");

	read_count_a: assert property (
		rd_en && addr == ADDR_COUNT |=>
		rdata == $past(timer2_count_q))
		else $error("count read returned wrong data");

	read_idle_a: assert property (
		!rd_en |=> rdata == 8'h00)
		else $error("read data outside a read cycle");

	write_period_a: assert property (
		wr_period |=> period_value_q == $past(wdata))
		else $error("period write lost");

	period_hold_a: assert property (
		!wr_period |=> $stable(period_value_q))
		else $error("period moved without a write");

endmodule // period_match_timer

`default_nettype wire

// ===== testbench/period_match_timer_tb.sv
// self-checking bench for the period match timer
`timescale 1ns/100ps
`default_nettype none

module period_match_timer_tb;
	import timer_pkg::*;
	logic clk_sys;
	logic nrst;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic wr_en;
	logic rd_en;
	logic [7:0] rdata;
	logic irq;
	logic post_pulse;
	int mismatches;
	int checked;
	int cyc;
	logic [7:0] v;
	int n;

	period_match_timer dut (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.addr(addr),
		.wdata(wdata),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rdata(rdata),
		.irq(irq),
		.post_pulse(post_pulse)
	);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic wrap_up();
		$display("counts: %0d checked, %0d mismatches", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// the tests need about 2100 cycles
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask

	// looks just after the edge, once the pulse register has settled
	task automatic wait_pulse(output int k);
		k = 0;
		@(posedge clk_sys);
		#1;
		while (post_pulse !== 1'b1 && k < 3000) begin
			k++;
			@(posedge clk_sys);
			#1;
		end
	endtask

	task automatic t_reset();
		rd(ADDR_COUNT, v);
		chk(v, 8'h00);
		rd(ADDR_PERIOD, v);
		chk(v, 8'hff);
		rd(ADDR_CONTROL, v);
		chk(v, 8'h00);
		rd(ADDR_STATUS, v);
		chk(v, 8'h00);
		chk(irq, 1'b0);
		chk(post_pulse, 1'b0);
		$display("reset test done");
	endtask

	task automatic t_regs();
		wr(ADDR_COUNT, 8'ha5);
		wr(ADDR_PERIOD, 8'h3c);
		wr(3'h5, 8'h77);
		rd(ADDR_COUNT, v);
		chk(v, 8'ha5);
		rd(ADDR_PERIOD, v);
		chk(v, 8'h3c);
		rd(3'h5, v);
		chk(v, 8'h00);
		wr(ADDR_CONTROL, 8'hfb);
		rd(ADDR_CONTROL, v);
		chk(v, 8'h7b);
		$display("register test done");
	endtask

	// interval = 4 * (period + 1) * prescale * (post + 1)
	task automatic t_rates();
		logic [1:0] pre [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
		logic [3:0] post [6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'hf, 4'h2};
		int ratio [6] = '{1, 4, 16, 16, 1, 4};
		wr(ADDR_PERIOD, 8'h02);
		wr(ADDR_COUNT, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_CONTROL, {1'b0, post[i], 1'b1, pre[i]});
			wait_pulse(n);
			wait_pulse(n);
			chk(16'(n + 1),
				16'(12 * ratio[i] * (post[i] + 1)));
		end
		$display("rate test done");
	endtask

	task automatic t_irq();
		rd(ADDR_STATUS, v);
		chk(v, 8'h01);
		chk(irq, 1'b0);
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_STATUS, 8'h00);
		rd(ADDR_STATUS, v);
		chk(v, 8'h01);
		wr(ADDR_MASK, 8'h01);
		#1 chk(irq, 1'b1);
		rd(ADDR_MASK, v);
		chk(v, 8'h01);
		wr(ADDR_STATUS, 8'h01);
		#1 chk(irq, 1'b0);
		rd(ADDR_STATUS, v);
		chk(v, 8'h00);
		wr(ADDR_CONTROL, 8'h04);
		wait_pulse(n);
		@(posedge clk_sys);
		#1 chk(irq, 1'b1);
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_STATUS, 8'h01);
		wr(ADDR_MASK, 8'h00);
		$display("interrupt test done");
	endtask

	// prescale 16: first step 61..64 cycles after the divider clear
	task automatic t_hold();
		wr(ADDR_PERIOD, 8'hff);
		wr(ADDR_COUNT, 8'h09);
		wr(ADDR_CONTROL, 8'h06);
		rd(ADDR_COUNT, v);
		chk(v, 8'h09);
		repeat (70) @(posedge clk_sys);
		rd(ADDR_COUNT, v);
		chk(v, 8'h0a);
		wr(ADDR_CONTROL, 8'h02);
		repeat (200) @(posedge clk_sys);
		rd(ADDR_COUNT, v);
		chk(v, 8'h0a);
		wr(ADDR_CONTROL, 8'h06);
		repeat (40) @(posedge clk_sys);
		wr(ADDR_COUNT, 8'h30);
		repeat (50) @(posedge clk_sys);
		rd(ADDR_COUNT, v);
		chk(v, 8'h30);
		$display("hold test done");
	endtask

	// reset in mid-run, with registers away from their reset values
	task automatic t_midreset();
		wr(ADDR_PERIOD, 8'h40);
		wr(ADDR_MASK, 8'h01);
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(ADDR_COUNT, v);
		chk(v, 8'h00);
		rd(ADDR_PERIOD, v);
		chk(v, 8'hff);
		rd(ADDR_CONTROL, v);
		chk(v, 8'h00);
		rd(ADDR_MASK, v);
		chk(v, 8'h00);
		chk(irq, 1'b0);
		$display("mid-run reset test done");
	endtask

	initial begin
		mismatches = 0;
		checked = 0;
		cyc = 0;
		nrst = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset();
		t_regs();
		t_rates();
		t_irq();
		t_hold();
		t_midreset();
		wrap_up();
	end
endmodule // period_match_timer_tb

`default_nettype wire
